// >>> logic/ccp_pkg.sv
// What this block does
// - interrupt pin active while enabled source pending, in serial port mode only
// - software picks interrupt pin polarity
// - interrupt pin active low after reset
// - reset pin low holds device in reset
// - chip select high: control traffic ignored
// - relay output switches only on ring sync in external ringing
package ccp_pkg;

  // number of interrupt sources, one bit each in the mask
  localparam int CCP_NUM_IRQ = 8;

  // reset values of the control state
  localparam logic CCP_POL_RESET = 1'b0;  // 0 = active low
  localparam logic [7:0] CCP_MASK_RESET = 8'h00;
  localparam logic [7:0] CCP_PEND_RESET = 8'h00;
  localparam logic CCP_RING_RESET = 1'b0;
  localparam logic CCP_RELAY_RESET = 1'b0;
  localparam logic CCP_SYNC_RESET = 1'b0;

  // position of single-bit settings in the command data byte
  localparam int CCP_POL_BIT = 0;
  localparam int CCP_RING_BIT = 0;
  localparam int CCP_RELAY_BIT = 0;

  typedef enum logic [2:0] {
    CCP_OP_NOP,
    CCP_OP_SET_POL,
    CCP_OP_SET_MASK,
    CCP_OP_CLR_PEND,
    CCP_OP_SET_RING,
    CCP_OP_SET_RELAY
  } ccp_op_t;

  typedef struct packed {
    ccp_op_t op;
    logic [7:0] data;
  } ccp_cmd_t;

  typedef struct packed {
    logic [7:0] pending;
    logic [7:0] mask;
    logic pol_high;
    logic ext_ring;
    logic relay_req;
  } ccp_status_t;

endpackage

// >>> logic/ccp_ring_sync.sv
`timescale 1ns/1ps
module ccp_ring_sync
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  import ccp_pkg::*;

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  // first stage feeds only the second stage
  always_comb
  begin
    meta_d = i_async;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      meta_q <= CCP_SYNC_RESET;
      sync_q <= CCP_SYNC_RESET;
      last_q <= CCP_SYNC_RESET;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // edge taken from settled stages only
  assign o_level = sync_q;
  assign o_rise = sync_q & ~last_q;

  a_sync_two_stage: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (!$past(i_rst) && !$past(i_rst, 2)) |-> o_level == $past(i_async, 2))
    else $error("ring sync level not two cycles behind input");

endmodule

// >>> logic/ccp_control_pins.sv
`timescale 1ns/1ps
module ccp_control_pins
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_reset_n,
  input wire logic i_host_serial_port_mode,
  input wire logic i_cs_n,
  input wire logic i_cmd_valid,
  input ccp_pkg::ccp_cmd_t i_cmd,
  input wire logic [ccp_pkg::CCP_NUM_IRQ-1:0] i_irq_event,
  input wire logic i_ring_sync_in,
  output logic o_cmd_ready,
  output logic o_int_pin,
  output logic o_relay_io_one,
  output ccp_pkg::ccp_status_t o_status
);
  import ccp_pkg::*;

  logic dev_rst;
  logic cmd_take;
  logic ring_level;
  logic ring_rise;
  logic irq_any;

  logic pol_q, pol_d;
  logic [CCP_NUM_IRQ-1:0] mask_q, mask_d;
  logic [CCP_NUM_IRQ-1:0] pend_q, pend_d;
  logic ring_q, ring_d;
  logic req_q, req_d;
  logic relay_q, relay_d;
  logic int_q, int_d;

  // chip reset pin is active low and sampled on the master clock
  assign dev_rst = i_rst | ~i_reset_n;

  // commands only while selected and in serial port mode
  assign o_cmd_ready = ~i_cs_n & i_host_serial_port_mode & ~dev_rst;
  assign cmd_take = i_cmd_valid & o_cmd_ready;

  // ring sync is an outside level, so resynchronise before use
  ccp_ring_sync u_ring_sync
  (
    .i_clock(i_clock),
    .i_rst(dev_rst),
    .i_async(i_ring_sync_in),
    .o_level(ring_level),
    .o_rise(ring_rise)
  );

  // settings written by the host
  always_comb
  begin
    pol_d = pol_q;
    mask_d = mask_q;
    ring_d = ring_q;
    req_d = req_q;
    if (cmd_take)
    begin
      case (i_cmd.op)
        CCP_OP_SET_POL: pol_d = i_cmd.data[CCP_POL_BIT];
        CCP_OP_SET_MASK: mask_d = i_cmd.data[CCP_NUM_IRQ-1:0];
        CCP_OP_SET_RING: ring_d = i_cmd.data[CCP_RING_BIT];
        CCP_OP_SET_RELAY: req_d = i_cmd.data[CCP_RELAY_BIT];
        default: pol_d = pol_q;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (dev_rst)
    begin
      pol_q <= CCP_POL_RESET;
      mask_q <= CCP_MASK_RESET;
      ring_q <= CCP_RING_RESET;
      req_q <= CCP_RELAY_RESET;
    end
    else
    begin
      pol_q <= pol_d;
      mask_q <= mask_d;
      ring_q <= ring_d;
      req_q <= req_d;
    end
  end

  // sticky pending bits; a new event beats a clear in the same cycle
  always_comb
  begin
    pend_d = pend_q;
    if (cmd_take && i_cmd.op == CCP_OP_CLR_PEND)
    begin
      pend_d = pend_q & ~i_cmd.data[CCP_NUM_IRQ-1:0];
    end
    pend_d = pend_d | i_irq_event;
  end

  always_ff @(posedge i_clock)
  begin
    if (dev_rst)
    begin
      pend_q <= CCP_PEND_RESET;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  // interrupt pin level: active level is the polarity bit itself
  assign irq_any = i_host_serial_port_mode & (|(pend_q & mask_q));
  always_comb
  begin
    int_d = irq_any ? pol_q : ~pol_q;
  end

  always_ff @(posedge i_clock)
  begin
    if (dev_rst)
    begin
      int_q <= ~CCP_POL_RESET;  // inactive for active low
    end
    else
    begin
      int_q <= int_d;
    end
  end

  // relay moves only on a ring sync rising edge in external ringing,
  // so the contact never breaks mid-burst
  always_comb
  begin
    relay_d = relay_q;
    if (!ring_q)
    begin
      relay_d = req_q;
    end
    else if (ring_rise)
    begin
      relay_d = req_q;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (dev_rst)
    begin
      relay_q <= CCP_RELAY_RESET;
    end
    else
    begin
      relay_q <= relay_d;
    end
  end

  // pins and status straight from flops, no glitches toward the board
  assign o_int_pin = int_q;
  assign o_relay_io_one = relay_q;
  assign o_status = '{pending: pend_q, mask: mask_q, pol_high: pol_q,
                      ext_ring: ring_q, relay_req: req_q};

  // checks except the two reset ones stay off through either reset, state is forced there
  a_int_follows_pending: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    irq_any |=> o_int_pin == $past(pol_q))
    else $error("interrupt pin not active while source pending");

  a_int_idle_level: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    !irq_any |=> o_int_pin != $past(pol_q))
    else $error("interrupt pin active with nothing pending");

  a_int_reset_low: assert property (
    @(posedge i_clock) disable iff (i_rst)
    $past(dev_rst) |-> (!pol_q && o_int_pin))
    else $error("interrupt pin not active low after reset");

  a_reset_pin_clears: assert property (
    @(posedge i_clock) disable iff (i_rst)
    $past(!i_reset_n) |-> (pend_q == CCP_PEND_RESET && !relay_q
                           && mask_q == CCP_MASK_RESET))
    else $error("state not reset while reset pin low");

  a_cs_blocks_cmd: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    (i_cs_n && i_cmd_valid) |=> ($stable(pol_q) && $stable(mask_q)
                                 && $stable(ring_q) && $stable(req_q)))
    else $error("command taken while chip select high");

  a_relay_holds: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    (ring_q && !ring_rise) |=> $stable(o_relay_io_one))
    else $error("relay switched without ring sync edge");

  a_relay_on_edge: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    (ring_q && ring_rise) |=> o_relay_io_one == $past(req_q))
    else $error("relay did not follow request at ring sync edge");

  a_event_beats_clear: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    (|i_irq_event) |=> (pend_q & $past(i_irq_event)) == $past(i_irq_event))
    else $error("pending bit lost to a clear in the same cycle");

  a_clear_drops_pend: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    (cmd_take && i_cmd.op == CCP_OP_CLR_PEND && !(|i_irq_event))
    |=> (pend_q & $past(i_cmd.data)) == '0)
    else $error("pending bit survived its clear");

  a_mode_low_idle: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    !i_host_serial_port_mode |=> o_int_pin != $past(pol_q))
    else $error("interrupt pin active outside serial port mode");

  a_ring_rise_edge: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    ring_rise == (ring_level && !$past(ring_level)))
    else $error("ring sync edge not taken from synchronised level");

  a_relay_direct: assert property (
    @(posedge i_clock) disable iff (dev_rst)
    !ring_q |=> o_relay_io_one == $past(req_q))
    else $error("relay did not follow request in internal ringing");

endmodule

// >>> bench/ccp_host_model.sv
`timescale 1ns/1ps
module ccp_host_model
(
  input wire logic i_clock,
  output logic o_cs_n,
  output logic o_cmd_valid,
  output ccp_pkg::ccp_cmd_t o_cmd
);
  import ccp_pkg::*;
  // idle: deselected
  initial
  begin
    o_cs_n = 1'b1;
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end
  // one word, paced by master clock
  task automatic send(input ccp_op_t op, input logic [7:0] d,
    input logic sel);
    @(posedge i_clock);
    #1;
    o_cs_n = ~sel;
    o_cmd_valid = 1'b1;
    o_cmd = {op, d};
    @(posedge i_clock);
    #1;
    o_cs_n = 1'b1;
    o_cmd_valid = 1'b0;
    o_cmd = ~o_cmd; // released bus never keeps last word
  endtask
endmodule

// >>> bench/tb_ccp_control_pins.sv
`timescale 1ns/1ps
module tb_ccp_control_pins;
  import ccp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rn = 1'b1;
  logic mode = 1'b1;
  logic ring = 1'b0;
  logic cs, v, pin, rly, rdy;
  logic [7:0] ev = 8'h00;
  logic [7:0] m, r;
  ccp_cmd_t cmd;
  ccp_status_t st;
  int num_errors = 0;
  int n_tests = 0;
  // 125 MHz
  always #4 clk = ~clk;
  ccp_host_model ccp_host_model_inst (.i_clock(clk), .o_cs_n(cs),
    .o_cmd_valid(v), .o_cmd(cmd));
  ccp_control_pins ccp_control_pins_inst (.i_clock(clk), .i_rst(rst),
    .i_reset_n(rn), .i_host_serial_port_mode(mode), .i_cs_n(cs),
    .i_cmd_valid(v), .i_cmd(cmd), .i_irq_event(ev),
    .i_ring_sync_in(ring), .o_cmd_ready(rdy), .o_int_pin(pin),
    .o_relay_io_one(rly), .o_status(st));
  // idle level is the inverse of the active one
  function automatic logic xpin(logic [7:0] p, logic [7:0] k, logic h);
    return ((p & k) != 8'h00) ? h : ~h;
  endfunction
  task automatic cbit(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %0t: bit %b not %b", $time, g, e);
    end
  endtask
  task automatic cbyte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %0t: byte %h not %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic snd(input ccp_op_t o, input logic [7:0] d,
    input logic s = 1'b1);
    ccp_host_model_inst.send(o, d, s);
  endtask
  // send one word and look at ready while the word stands
  task automatic snd_rdy(input ccp_op_t o, input logic [7:0] d,
    input logic s, input logic e);
    fork
      snd(o, d, s);
      begin
        tick(1);
        #1;
        cbit(rdy, e);
      end
    join
  endtask
  // hang guard, far past the few hundred cycles
  initial
  begin
    #40000;
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    void'($urandom(5938));
    tick(5);
    rst = 1'b0;
    tick(2);
    cbit(pin, 1'b1);
    cbit(st.pol_high, 1'b0);
    snd_rdy(CCP_OP_SET_MASK, 8'hFF, 1'b0, 1'b0);
    cbyte(st.mask, 8'h00);
    // first two passes: masked-out then enabled source
    for (int i = 0; i < 16; i++)
    begin
      m = (i < 2) ? 8'h81 : 8'($urandom);
      r = (i == 0) ? 8'h7E : (i == 1) ? 8'h80 : 8'($urandom);
      snd_rdy(CCP_OP_SET_POL, 8'(i % 2), 1'b1, 1'b1);
      snd(CCP_OP_SET_MASK, m);
      snd(CCP_OP_CLR_PEND, 8'hFF);
      tick(1);
      cbit(pin, xpin(8'h00, m, i[0]));
      ev = r;
      tick(1);
      ev = 8'h00;
      tick(1);
      cbyte(st.pending, r);
      cbit(pin, xpin(r, m, i[0]));
    end
    // clear and new event in one cycle: the event must win
    fork
      snd(CCP_OP_CLR_PEND, 8'hFF);
      begin
        tick(1);
        ev = 8'h01;
        tick(1);
        ev = 8'h00;
      end
    join
    cbyte(st.pending, 8'h01);
    snd(CCP_OP_SET_MASK, 8'h01);
    tick(1);
    cbit(pin, xpin(8'h01, 8'h01, 1'b1));
    // outside serial port mode: no commands, pin idle
    mode = 1'b0;
    snd_rdy(CCP_OP_SET_MASK, 8'h00, 1'b1, 1'b0);
    cbyte(st.mask, 8'h01);
    cbit(pin, xpin(8'h00, 8'h01, 1'b1));
    mode = 1'b1;
    snd(CCP_OP_SET_RELAY, 8'h01);
    tick(1);
    cbit(rly, 1'b1);
    snd(CCP_OP_SET_RING, 8'h01);
    snd(CCP_OP_SET_RELAY, 8'h00);
    tick(4);
    cbit(rly, 1'b1);
    cbit(st.ext_ring, 1'b1);
    cbit(st.relay_req, 1'b0);
    ring = 1'b1;
    tick(2);
    cbit(rly, 1'b1);
    tick(2);
    cbit(rly, 1'b0);
    // a falling ring edge must not switch
    snd(CCP_OP_SET_RELAY, 8'h01);
    ring = 1'b0;
    tick(4);
    cbit(rly, 1'b0);
    rn = 1'b0;
    tick(1);
    rn = 1'b1;
    cbit(st.ext_ring, 1'b0);
    cbit(st.pol_high, 1'b0);
    cbit(pin, 1'b1);
    cbyte(st.pending, 8'h00);
    cbyte(st.mask, 8'h00);
    tick(1);
    cbit(pin, 1'b1);
    report_and_stop();
  end
endmodule
